/* File: bench/wrm_far_side.sv */
// far side model: host pin event, ramp and power-down completion
// assumes one clock; i_delay sets how promptly completion answers
`timescale 1ns/10ps
`default_nettype none
module wrm_far_side (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_fire,
   input wire logic [7:0] i_delay,
   input wire logic [4:0] i_ramp,
   input wire logic i_pd_req,
   output logic o_event,
   output logic o_ramp_done,
   output logic o_pd_done
);
   logic [7:0] cnt;
   // completion is one pulse for any i_delay below FF, so a late sampler cannot see it twice
   always_ff @(posedge i_ref_clk)
   begin
      o_event <= i_fire;
      if (!i_rst_n || !((|i_ramp) || i_pd_req))
         cnt <= 8'h00;
      else if (cnt != 8'hFF)
         cnt <= cnt + 8'h01;
      o_ramp_done <= (|i_ramp) && cnt == i_delay;
      o_pd_done <= i_pd_req && cnt == i_delay;
   end
endmodule : wrm_far_side
`default_nettype wire

/* File: bench/wrm_properties.sv */
// checker: timing relations between the reset manager's ports
// assumes it is bound to the design top with every port named alike
`timescale 1ns/10ps
`default_nettype none
module wrm_properties (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_ramp_done,
   input wire logic i_external_fail_line_n,
   input wire logic o_host_reset_output_n,
   input wire logic o_pd_request,
   input wire logic o_power_good_output,
   input wire logic o_fail_safe,
   input wire logic [wrm_pkg::WRM_NUM_SW-1:0] o_switcher_ramp,
   input wire wrm_pkg::wrm_regcfg_s [wrm_pkg::WRM_NUM_REG-1:0] o_regulator
);
   logic any_on;
   logic bad_ramp;
   // any regulator still on, or a ramp on a switcher that should not move
   always_comb
   begin
      any_on = 1'b0;
      bad_ramp = 1'b0;
      for (int i = 0; i < wrm_pkg::WRM_NUM_REG; i++)
         any_on = any_on | o_regulator[i].on;
      for (int i = 0; i < wrm_pkg::WRM_NUM_SW; i++)
         bad_ramp = bad_ramp | (o_switcher_ramp[i] & (o_regulator[i].keep | !o_regulator[i].in_seq));
   end
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   soft_host_high_a: assert property ((|o_switcher_ramp) |-> o_host_reset_output_n)
      else $error("host reset dropped during soft reset");
   pd_host_low_a: assert property (o_pd_request |-> !o_host_reset_output_n)
      else $error("host reset high during power-down");
   pd_regs_off_a: assert property ($rose(o_pd_request) |-> !any_on [*2])
      else $error("regulator on during power-down");
   pd_pg_off_a: assert property (o_pd_request |-> !o_power_good_output)
      else $error("power good high during power-down");
   fail_hold_a: assert property (o_fail_safe |=> o_fail_safe)
      else $error("fail-safe left without reset");
   fail_line_a: assert property ($rose(o_host_reset_output_n) |-> $past(i_external_fail_line_n))
      else $error("power-up while fail line low");
   ramp_end_a: assert property ($fell(|o_switcher_ramp) |-> $past(i_ramp_done))
      else $error("ramp ended without ramp done");
   ramp_scope_a: assert property (!bad_ramp)
      else $error("ramp on kept or unsequenced switcher");
endmodule : wrm_properties
bind wrm_watchdog_reset_manager wrm_properties u_props (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
   .i_ramp_done(i_ramp_done), .i_external_fail_line_n(i_external_fail_line_n),
   .o_host_reset_output_n(o_host_reset_output_n), .o_pd_request(o_pd_request),
   .o_power_good_output(o_power_good_output), .o_fail_safe(o_fail_safe),
   .o_switcher_ramp(o_switcher_ramp), .o_regulator(o_regulator));
`default_nettype wire

/* File: bench/wrm_watchdog_reset_manager_test.sv */
// testbench: soft, hard, internal and fail-safe sequences of the reset manager
// assumes the far side model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module wrm_watchdog_reset_manager_test;
   logic i_ref_clk, i_rst_n, wr_stb, rd_stb, fire, texp, pur, stby, fail_n, rd_d, ev, rdone, pdone;
   logic [7:0] addr, wdata, rdata, dly, v, ctrl_def;
   logic host_n, int_n, trun, pd_req, pg, fs;
   logic [3:0] wlen;
   logic [4:0] ramp;
   wrm_pkg::wrm_regcfg_s [wrm_pkg::WRM_NUM_REG-1:0] regs;
   wrm_pkg::wrm_otp_s otp;
   logic [7:0] exp_q[$];
   int failures, n_tests, seed, n;
   wrm_watchdog_reset_manager i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(addr),
      .i_wdata(wdata), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .i_watch_input_event(ev),
      .i_timer_expire(texp), .i_timer_refresh(1'b0), .i_power_up_request(pur),
      .i_standby_request(stby), .i_external_fail_line_n(fail_n), .i_ramp_done(rdone),
      .i_pd_done(pdone), .i_otp(otp), .o_rdata(rdata), .o_host_reset_output_n(host_n),
      .o_interrupt_output_n(int_n), .o_timer_run(trun), .o_watch_window_length(wlen),
      .o_pd_request(pd_req), .o_power_good_output(pg), .o_fail_safe(fs),
      .o_switcher_ramp(ramp), .o_regulator(regs));
   wrm_far_side i_far (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_fire(fire), .i_delay(dly),
      .i_ramp(ramp), .i_pd_req(pd_req), .o_event(ev), .o_ramp_done(rdone), .o_pd_done(pdone));
   initial
   begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   task final_report;
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
   task chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", s, exp, seen);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      addr <= a; wdata <= d; wr_stb <= 1'b1;
      @(posedge i_ref_clk);
      wr_stb <= 1'b0;
   endtask : wr
   // the expected word waits in the queue until the read slot comes
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_ref_clk);
      addr <= a; rd_stb <= 1'b1; exp_q.push_back(e);
      @(posedge i_ref_clk);
      rd_stb <= 1'b0;
   endtask : rd
   // s=1 pin event via the far side, s=0 internal expiry; ends past the taking edge
   task pulse(input int s);
      @(posedge i_ref_clk);
      if (s == 1) fire <= 1'b1; else texp <= 1'b1;
      @(posedge i_ref_clk);
      fire <= 1'b0; texp <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      #1;
   endtask : pulse
   function logic pick(input int s);
      case (s)
         0: pick = host_n;
         1: pick = int_n;
         default: pick = |ramp;
      endcase
   endfunction : pick
   // bounded wait; n gives the edges spent
   task wait_for(input int s, input logic lvl, input int lim);
      n = 0;
      while (pick(s) !== lvl && n < lim)
      begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
      if (n >= lim)
      begin
         failures++;
         $display("[FAIL] wait %0d expected %b seen timeout", s, lvl);
         final_report();
      end
   endtask : wait_for
   // read data stand only in the cycle after the strobe
   always @(posedge i_ref_clk) rd_d <= rd_stb;
   always @(negedge i_ref_clk)
      if (rd_d === 1'b1) chk("rdata", rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX);
   initial
   begin
      seed = 12;
      {i_rst_n, wr_stb, rd_stb, fire, texp, pur, stby, addr, wdata} = '0;
      fail_n = 1'b1; dly = 8'h04; failures = 0; n_tests = 0;
      otp = '0;
      otp.standby_watch_default = 1'b1; otp.watch_enable = 1'b1; otp.window_length = 4'h5;
      otp.event_limit_default = 4'h3; otp.expiry_limit = 3'h4; otp.input_standby_active = 1'b1;
      otp.pg_gpo = 1'b1; otp.pg_in_seq = 1'b1;
      for (int i = 0; i < wrm_pkg::WRM_NUM_REG; i++)
      begin
         otp.regs[i].in_seq = (i != 1 && i != 6);
         otp.regs[i].volt = $random(seed);
      end
      ctrl_def = {2'b00, otp.pg_in_seq, otp.pg_gpo, otp.input_standby_active, otp.input_reset_type,
         otp.standby_watch_default, otp.watch_enable};
      repeat (3) @(posedge i_ref_clk);
      i_rst_n <= 1'b1; pur <= 1'b1;
      wait_for(0, 1'b1, 50);
      rd(8'h00, ctrl_def);
      rd(8'h03, 8'h30);
      // soft reset: switcher 2 kept, switcher 0 and regulator 5 disturbed first
      v = $random(seed);
      wr(8'h12, 8'h07); wr(8'h1A, v); wr(8'h18, ~otp.regs[0].volt); wr(8'h1D, ~otp.regs[5].volt);
      pulse(1);
      chk("ramp", ramp, 5'b11001);
      chk("sw0 volt", regs[0].volt, otp.regs[0].volt);
      chk("sw2 volt", regs[2].volt, v);
      chk("sw1 on", regs[1].on, 1'b0);
      chk("ldo volt", regs[5].volt, otp.regs[5].volt);
      wait_for(2, 1'b0, 300);
      wait_for(1, 1'b0, 4000);
      chk("settle", n >= wrm_pkg::WRM_SETTLE_CYC - 1 && n <= wrm_pkg::WRM_SETTLE_CYC + 2, 1'b1);
      rd(8'h05, 8'h01);
      rd(8'h03, 8'h31);
      wr(8'h04, 8'h01); wr(8'h03, 8'h30);
      rd(8'h03, 8'h30);
      // masked soft reset keeps the interrupt quiet
      wr(8'h04, 8'h02);
      pulse(1);
      repeat (3200) @(posedge i_ref_clk);
      #1;
      chk("masked int", int_n, 1'b1);
      rd(8'h04, 8'h03);
      // hard reset held by the fail line, slow power-down, standby after
      dly <= 8'h40;
      wr(8'h00, ctrl_def | 8'h04);
      @(posedge i_ref_clk);
      stby <= 1'b1; fail_n <= 1'b0;
      pulse(1);
      chk("pd req", pd_req, 1'b1);
      chk("host low", host_n, 1'b0);
      repeat (3200) @(posedge i_ref_clk);
      #1;
      chk("held", host_n, 1'b0);
      @(posedge i_ref_clk);
      fail_n <= 1'b1;
      wait_for(0, 1'b1, 10);
      rd(8'h05, 8'h02);
      rd(8'h00, ctrl_def);
      chk("wlen", wlen, 8'h05);
      rd(8'h03, 8'h32);
      // standby timer gating, then internal expiry
      chk("stby run", trun, 1'b1);
      wr(8'h00, ctrl_def & 8'hFD);
      repeat (2) @(posedge i_ref_clk);
      #1;
      chk("stby halt", trun, 1'b0);
      wr(8'h00, ctrl_def); wr(8'h03, 8'h30);
      pulse(0);
      chk("one expiry", pd_req, 1'b0);
      pulse(0);
      chk("expiry hard", pd_req, 1'b1);
      wait_for(0, 1'b1, 3500);
      wr(8'h03, 8'h10);
      pulse(1);
      chk("fail safe", fs, 1'b1);
      rd(8'h05, 8'h18);
      @(posedge i_ref_clk);
      i_rst_n <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      wait_for(0, 1'b1, 50);
      rd(8'h03, 8'h30);
      repeat (2) @(posedge i_ref_clk);
      final_report();
   end
endmodule : wrm_watchdog_reset_manager_test
`default_nettype wire

/* File: hdl/wrm_pkg.sv */
// watchdog reset manager: register offsets, field positions, reset values,
// states and the packed carriers shared by the design and its bench.
// assumes a 100 MHz reference clock and 8-bit register data.
package wrm_pkg;

   // regulator population: switchers first, then linear regulators
   localparam int WRM_NUM_SW = 5;
   localparam int WRM_NUM_REG = 7;

   // register offsets
   localparam logic [7:0] WRM_ADDR_CTRL = 8'h00;
   localparam logic [7:0] WRM_ADDR_WINDOW = 8'h01;
   localparam logic [7:0] WRM_ADDR_EXPIRY = 8'h02;
   localparam logic [7:0] WRM_ADDR_EVENT = 8'h03;
   localparam logic [7:0] WRM_ADDR_INT = 8'h04;
   localparam logic [7:0] WRM_ADDR_STATUS = 8'h05;
   localparam logic [4:0] WRM_ADDR_CFG_BASE = 5'h02;
   localparam logic [4:0] WRM_ADDR_VOLT_BASE = 5'h03;

   // control register field positions
   localparam int WRM_CTRL_WATCH_EN = 0;
   localparam int WRM_CTRL_STBY_WATCH_EN = 1;
   localparam int WRM_CTRL_INPUT_TYPE = 2;
   localparam int WRM_CTRL_INPUT_STBY = 3;
   localparam int WRM_CTRL_PG_GPO = 4;
   localparam int WRM_CTRL_PG_IN_SEQ = 5;

   // regulator config register field positions
   localparam int WRM_CFG_KEEP = 0;
   localparam int WRM_CFG_IN_SEQ = 1;
   localparam int WRM_CFG_ON = 2;

   // interrupt register field positions
   localparam int WRM_INT_FLAG = 0;
   localparam int WRM_INT_MASK = 1;

   // expiry tally steps
   localparam logic [2:0] WRM_TALLY_UP = 3'h2;
   localparam logic [2:0] WRM_TALLY_DOWN = 3'h1;
   localparam logic [2:0] WRM_TALLY_MAX = 3'h7;

   // settle delay after a reset sequence
   localparam int WRM_CLK_MHZ = 100;
   localparam int WRM_SETTLE_US = 30;
   localparam int WRM_SETTLE_CYC = WRM_SETTLE_US * WRM_CLK_MHZ;
   localparam int WRM_CNT_W = 12;

   typedef enum logic [3:0] {
      WRM_OFF = 4'h0,
      WRM_RUN = 4'h1,
      WRM_STBY = 4'h2,
      WRM_SOFT_RAMP = 4'h3,
      WRM_SOFT_WAIT = 4'h4,
      WRM_HARD_PD = 4'h5,
      WRM_HARD_WAIT = 4'h6,
      WRM_HARD_HOLD = 4'h7,
      WRM_FAIL_SAFE = 4'h8
   } wrm_state_e;

   typedef struct packed {
      logic keep;
      logic in_seq;
      logic on;
      logic [7:0] volt;
   } wrm_regcfg_s;

   // programmed defaults as presented by the fuse array
   typedef struct packed {
      logic standby_watch_default;
      logic watch_enable;
      logic [3:0] window_length;
      logic [3:0] event_limit_default;
      logic [2:0] expiry_limit;
      logic input_reset_type;
      logic input_standby_active;
      logic pg_gpo;
      logic pg_in_seq;
      wrm_regcfg_s [WRM_NUM_REG-1:0] regs;
   } wrm_otp_s;

   typedef struct packed {
      wrm_state_e fsm;
      logic [WRM_CNT_W-1:0] settle_cnt;
      logic watch_enable;
      logic standby_watch_enable;
      logic input_reset_type;
      logic input_standby_active;
      logic pg_gpo;
      logic pg_in_seq;
      logic [3:0] window_length;
      logic [2:0] expiry_limit;
      logic [2:0] tally;
      logic [3:0] event_cnt;
      logic [3:0] event_limit;
      logic flag;
      logic mask;
      wrm_regcfg_s [WRM_NUM_REG-1:0] regs;
      logic [WRM_NUM_SW-1:0] sw_ramp;
      logic host_reset_n;
      logic interrupt_n;
      logic timer_run;
      logic pd_req;
      logic pg_out;
      logic fail_safe;
      logic [7:0] rdata;
   } wrm_state_s;

   localparam wrm_state_s WRM_STATE_RESET = '{fsm: WRM_OFF, interrupt_n: 1'b1, default: '0};

endpackage : wrm_pkg

/* File: hdl/wrm_watchdog_reset_manager.sv */
// watchdog reset manager: event detection, soft and hard reset sequencing,
// event counting and the register port that steers it.
// assumes synchronous inputs, a plain strobe register port, and an outside
// window timer, regulator sequencer and power-down sequencer.
//
// Overview of operation
// - watchdog timer runs in standby only when standby watch enable is set
// - standby watch enable powers up from its programmed default
// - every watchdog event below the limit starts either a soft or a hard reset
// - host reset output stays deasserted for the whole soft reset
// - soft reset reloads the fixed subset of configuration bits
// - soft reset reloads each non-kept switcher's settings and voltages
// - soft reset reloads each non-kept linear regulator's settings and voltages
// - regulators with keep-config set are untouched by a soft reset
// - all non-kept regulators return to default voltage, in the power-up sequence or not
// - switchers ramp to the default voltage, linear regulators step at once
// - non-kept regulators outside the power-up sequence switch off at once
// - after ramps end wait 30 us, return to run or standby, set flag; interrupt unless masked
// - hard reset restores every setting from programmed defaults
// - hard reset turns all regulators off and asserts host reset
// - power good general output is disabled during hard power-down
// - after power-down wait 30 us, reload, hold while external fail low
// - after either reset enter standby if standby request is high
// - each event increments counter; reaching limit enters fail-safe
// - event limit powers up from its programmed default
// - every pass through off clears the event counter
// - input pin event type follows reset-type bit; internal events are hard
// - internal event when expiry tally reaches expiry limit
`timescale 1ns/10ps
`default_nettype none

module wrm_watchdog_reset_manager (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr_stb,
   input wire logic i_rd_stb,
   input wire logic i_watch_input_event,
   input wire logic i_timer_expire,
   input wire logic i_timer_refresh,
   input wire logic i_power_up_request,
   input wire logic i_standby_request,
   input wire logic i_external_fail_line_n,
   input wire logic i_ramp_done,
   input wire logic i_pd_done,
   input wire wrm_pkg::wrm_otp_s i_otp,
   output logic [7:0] o_rdata,
   output logic o_host_reset_output_n,
   output logic o_interrupt_output_n,
   output logic o_timer_run,
   output logic [3:0] o_watch_window_length,
   output logic o_pd_request,
   output logic o_power_good_output,
   output logic o_fail_safe,
   output logic [wrm_pkg::WRM_NUM_SW-1:0] o_switcher_ramp,
   output wrm_pkg::wrm_regcfg_s [wrm_pkg::WRM_NUM_REG-1:0] o_regulator
);

   wrm_pkg::wrm_state_s st;
   wrm_pkg::wrm_state_s next_st;

   // soft reload of one regulator: kept ones untouched, others back to default
   function automatic wrm_pkg::wrm_regcfg_s soft_reload(input wrm_pkg::wrm_regcfg_s cur,
                                                        input wrm_pkg::wrm_regcfg_s dflt);
      wrm_pkg::wrm_regcfg_s r;
      r = cur;
      if (!cur.keep)
      begin
         r = dflt;
         r.on = dflt.in_seq;
      end
      return r;
   endfunction : soft_reload

   // the settle counter ends on its last cycle
   function automatic logic settle_end(input logic [wrm_pkg::WRM_CNT_W-1:0] cnt);
      return cnt == wrm_pkg::WRM_CNT_W'(wrm_pkg::WRM_SETTLE_CYC - 1);
   endfunction : settle_end

   // run or standby after a reset sequence, by the standby request pin
   function automatic wrm_pkg::wrm_state_e on_state(input logic stby);
      return stby ? wrm_pkg::WRM_STBY : wrm_pkg::WRM_RUN;
   endfunction : on_state

   always_comb
   begin
      logic on_mode;
      logic expire_hit;
      logic input_hit;
      logic [3:0] cnt_inc;
      logic [3:0] tally_sum;
      logic [2:0] idx;
      next_st = st;
      on_mode = (st.fsm == wrm_pkg::WRM_RUN) || (st.fsm == wrm_pkg::WRM_STBY);
      expire_hit = 1'b0;
      input_hit = 1'b0;
      cnt_inc = st.event_cnt + 4'h1;
      tally_sum = 4'h0;
      idx = i_addr[2:0];

      // read data stand for exactly the cycle after the strobe
      next_st.rdata = 8'h00;
      if (i_rd_stb)
      begin
         case (i_addr)
            wrm_pkg::WRM_ADDR_CTRL:
               next_st.rdata = {2'b00, st.pg_in_seq, st.pg_gpo, st.input_standby_active,
                                st.input_reset_type, st.standby_watch_enable, st.watch_enable};
            wrm_pkg::WRM_ADDR_WINDOW: next_st.rdata = {4'h0, st.window_length};
            wrm_pkg::WRM_ADDR_EXPIRY: next_st.rdata = {1'b0, st.tally, 1'b0, st.expiry_limit};
            wrm_pkg::WRM_ADDR_EVENT: next_st.rdata = {st.event_limit, st.event_cnt};
            wrm_pkg::WRM_ADDR_INT: next_st.rdata = {6'h00, st.mask, st.flag};
            wrm_pkg::WRM_ADDR_STATUS: next_st.rdata = {3'h0, st.fail_safe, st.fsm};
            default:
            begin
               if (i_addr[7:3] == wrm_pkg::WRM_ADDR_CFG_BASE && idx < 3'(wrm_pkg::WRM_NUM_REG))
                  next_st.rdata = {5'h00, st.regs[idx].on, st.regs[idx].in_seq, st.regs[idx].keep};
               else if (i_addr[7:3] == wrm_pkg::WRM_ADDR_VOLT_BASE && idx < 3'(wrm_pkg::WRM_NUM_REG))
                  next_st.rdata = st.regs[idx].volt;
            end
         endcase
      end

      // register writes; hardware updates below take priority over them
      if (i_wr_stb)
      begin
         case (i_addr)
            wrm_pkg::WRM_ADDR_CTRL:
            begin
               next_st.watch_enable = i_wdata[wrm_pkg::WRM_CTRL_WATCH_EN];
               next_st.standby_watch_enable = i_wdata[wrm_pkg::WRM_CTRL_STBY_WATCH_EN];
               next_st.input_reset_type = i_wdata[wrm_pkg::WRM_CTRL_INPUT_TYPE];
               next_st.input_standby_active = i_wdata[wrm_pkg::WRM_CTRL_INPUT_STBY];
               next_st.pg_gpo = i_wdata[wrm_pkg::WRM_CTRL_PG_GPO];
               next_st.pg_in_seq = i_wdata[wrm_pkg::WRM_CTRL_PG_IN_SEQ];
            end
            wrm_pkg::WRM_ADDR_WINDOW: next_st.window_length = i_wdata[3:0];
            wrm_pkg::WRM_ADDR_EXPIRY: next_st.expiry_limit = i_wdata[2:0];
            wrm_pkg::WRM_ADDR_EVENT:
            begin
               next_st.event_cnt = 4'h0;
               next_st.event_limit = i_wdata[7:4];
            end
            wrm_pkg::WRM_ADDR_INT:
            begin
               if (i_wdata[wrm_pkg::WRM_INT_FLAG])
                  next_st.flag = 1'b0;
               next_st.mask = i_wdata[wrm_pkg::WRM_INT_MASK];
            end
            default:
            begin
               if (i_addr[7:3] == wrm_pkg::WRM_ADDR_CFG_BASE && idx < 3'(wrm_pkg::WRM_NUM_REG))
               begin
                  next_st.regs[idx].keep = i_wdata[wrm_pkg::WRM_CFG_KEEP];
                  next_st.regs[idx].in_seq = i_wdata[wrm_pkg::WRM_CFG_IN_SEQ];
                  next_st.regs[idx].on = i_wdata[wrm_pkg::WRM_CFG_ON];
               end
               else if (i_addr[7:3] == wrm_pkg::WRM_ADDR_VOLT_BASE && idx < 3'(wrm_pkg::WRM_NUM_REG))
                  next_st.regs[idx].volt = i_wdata;
            end
         endcase
      end

      // expiry tally: up by two on a missed refresh, down by one on a good one
      if (on_mode && st.timer_run)
      begin
         if (i_timer_expire)
         begin
            tally_sum = {1'b0, st.tally} + {1'b0, wrm_pkg::WRM_TALLY_UP};
            next_st.tally = tally_sum[3] ? wrm_pkg::WRM_TALLY_MAX : tally_sum[2:0];
            // limits at or below the first step fire on the first expiry
            expire_hit = (next_st.tally >= st.expiry_limit);
         end
         else if (i_timer_refresh && st.tally != 3'h0)
            next_st.tally = st.tally - wrm_pkg::WRM_TALLY_DOWN;
      end
      // the input pin only counts in standby when its standby activity is set
      input_hit = i_watch_input_event &&
                  (st.fsm == wrm_pkg::WRM_RUN || (st.fsm == wrm_pkg::WRM_STBY && st.input_standby_active));

      next_st.settle_cnt = '0;
      next_st.sw_ramp = '0;
      next_st.pd_req = 1'b0;
      case (st.fsm)
         wrm_pkg::WRM_OFF:
         begin
            next_st.event_cnt = 4'h0;
            next_st.tally = 3'h0;
            next_st.host_reset_n = 1'b0;
            for (int i = 0; i < wrm_pkg::WRM_NUM_REG; i++)
               next_st.regs[i].on = 1'b0;
            if (i_power_up_request && i_external_fail_line_n)
            begin
               next_st.standby_watch_enable = i_otp.standby_watch_default;
               next_st.event_limit = i_otp.event_limit_default;
               next_st.watch_enable = i_otp.watch_enable;
               next_st.window_length = i_otp.window_length;
               next_st.expiry_limit = i_otp.expiry_limit;
               next_st.input_reset_type = i_otp.input_reset_type;
               next_st.input_standby_active = i_otp.input_standby_active;
               next_st.pg_gpo = i_otp.pg_gpo;
               next_st.pg_in_seq = i_otp.pg_in_seq;
               for (int i = 0; i < wrm_pkg::WRM_NUM_REG; i++)
               begin
                  next_st.regs[i] = i_otp.regs[i];
                  next_st.regs[i].on = i_otp.regs[i].in_seq;
               end
               next_st.host_reset_n = 1'b1;
               next_st.fsm = on_state(i_standby_request);
            end
         end
         wrm_pkg::WRM_RUN, wrm_pkg::WRM_STBY:
         begin
            next_st.fsm = on_state(i_standby_request);
            if (input_hit || expire_hit)
            begin
               next_st.event_cnt = cnt_inc;
               next_st.tally = 3'h0;
               if (cnt_inc == st.event_limit)
                  next_st.fsm = wrm_pkg::WRM_FAIL_SAFE;
               else if (expire_hit || st.input_reset_type)
                  next_st.fsm = wrm_pkg::WRM_HARD_PD;
               else
               begin
                  next_st.fsm = wrm_pkg::WRM_SOFT_RAMP;
                  // configuration subset reload
                  next_st.watch_enable = i_otp.watch_enable;
                  next_st.window_length = i_otp.window_length;
                  next_st.standby_watch_enable = i_otp.standby_watch_default;
                  next_st.input_standby_active = i_otp.input_standby_active;
                  next_st.pg_gpo = i_otp.pg_gpo;
                  next_st.pg_in_seq = i_otp.pg_in_seq;
                  for (int i = 0; i < wrm_pkg::WRM_NUM_REG; i++)
                     next_st.regs[i] = soft_reload(st.regs[i], i_otp.regs[i]);
                  // linear regulators take the new voltage at once, switchers ramp
                  for (int i = 0; i < wrm_pkg::WRM_NUM_SW; i++)
                     next_st.sw_ramp[i] = !st.regs[i].keep && i_otp.regs[i].in_seq;
               end
            end
         end
         wrm_pkg::WRM_SOFT_RAMP:
         begin
            next_st.host_reset_n = 1'b1;
            next_st.sw_ramp = i_ramp_done ? '0 : st.sw_ramp;
            if (i_ramp_done)
               next_st.fsm = wrm_pkg::WRM_SOFT_WAIT;
         end
         wrm_pkg::WRM_SOFT_WAIT:
         begin
            next_st.host_reset_n = 1'b1;
            next_st.settle_cnt = st.settle_cnt + 1'b1;
            if (settle_end(st.settle_cnt))
            begin
               next_st.fsm = on_state(i_standby_request);
               next_st.flag = 1'b1;
            end
         end
         wrm_pkg::WRM_HARD_PD:
         begin
            // the external sequencer orders the outputs; we only request it
            next_st.host_reset_n = 1'b0;
            next_st.pd_req = !i_pd_done;
            for (int i = 0; i < wrm_pkg::WRM_NUM_REG; i++)
               next_st.regs[i].on = 1'b0;
            if (i_pd_done)
               next_st.fsm = wrm_pkg::WRM_HARD_WAIT;
         end
         wrm_pkg::WRM_HARD_WAIT:
         begin
            next_st.settle_cnt = st.settle_cnt + 1'b1;
            if (settle_end(st.settle_cnt))
            begin
               next_st.fsm = wrm_pkg::WRM_HARD_HOLD;
               next_st.watch_enable = i_otp.watch_enable;
               next_st.standby_watch_enable = i_otp.standby_watch_default;
               next_st.input_reset_type = i_otp.input_reset_type;
               next_st.input_standby_active = i_otp.input_standby_active;
               next_st.pg_gpo = i_otp.pg_gpo;
               next_st.pg_in_seq = i_otp.pg_in_seq;
               next_st.window_length = i_otp.window_length;
               next_st.expiry_limit = i_otp.expiry_limit;
               next_st.event_limit = i_otp.event_limit_default;
               next_st.mask = 1'b0;
               for (int i = 0; i < wrm_pkg::WRM_NUM_REG; i++)
               begin
                  next_st.regs[i] = i_otp.regs[i];
                  next_st.regs[i].on = 1'b0;
               end
            end
         end
         wrm_pkg::WRM_HARD_HOLD:
         begin
            // power-up is held off while the external fail line is low
            if (i_external_fail_line_n)
            begin
               for (int i = 0; i < wrm_pkg::WRM_NUM_REG; i++)
                  next_st.regs[i].on = st.regs[i].in_seq;
               next_st.host_reset_n = 1'b1;
               next_st.fsm = on_state(i_standby_request);
            end
         end
         wrm_pkg::WRM_FAIL_SAFE:
         begin
            // only a reset leaves fail-safe; outputs stay parked
            next_st.host_reset_n = 1'b0;
            for (int i = 0; i < wrm_pkg::WRM_NUM_REG; i++)
               next_st.regs[i].on = 1'b0;
         end
         default: next_st = wrm_pkg::WRM_STATE_RESET;
      endcase

      next_st.fail_safe = (next_st.fsm == wrm_pkg::WRM_FAIL_SAFE);
      // timer runs in run when watch is enabled, in standby only when also allowed
      next_st.timer_run = next_st.watch_enable && (next_st.fsm == wrm_pkg::WRM_RUN ||
                          (next_st.fsm == wrm_pkg::WRM_STBY && next_st.standby_watch_enable));
      // power good general output drops with the host reset in a hard reset
      next_st.pg_out = next_st.pg_gpo && next_st.pg_in_seq && next_st.host_reset_n;
      next_st.interrupt_n = !(next_st.flag && !next_st.mask);
   end

   // single state register, synchronous active-low reset
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
         st <= wrm_pkg::WRM_STATE_RESET;
      else
         st <= next_st;
   end

   // every output is a field of the state register
   assign o_rdata = st.rdata;
   assign o_host_reset_output_n = st.host_reset_n;
   assign o_interrupt_output_n = st.interrupt_n;
   assign o_timer_run = st.timer_run;
   assign o_watch_window_length = st.window_length;
   assign o_pd_request = st.pd_req;
   assign o_power_good_output = st.pg_out;
   assign o_fail_safe = st.fail_safe;
   assign o_switcher_ramp = st.sw_ramp;
   assign o_regulator = st.regs;

endmodule : wrm_watchdog_reset_manager

`default_nettype wire
